// File: design/cidr_pkg.sv
package cidr_pkg;
   // Core clock and time base; slow delays count 100 us ticks.
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_US       = 100;
   localparam int TICK_CYC      = TICK_US * 1000 / CLK_PERIOD_NS;
   localparam int LINE_BAUD     = 1200;
   localparam int BIT_CYC       = 1000000000 / (LINE_BAUD * CLK_PERIOD_NS);

   // Dual-tone and call-progress timing, figures as printed.
   localparam int CAS_STEP_US   = 2800;
   localparam int CAS_ON_US     = 16900;
   localparam int CAS_OFF_US    = 13100;
   localparam int CPM_ON_MS     = 25;
   localparam int CPM_OFF_MS    = 30;
   localparam int CAS_STEP_TK   = CAS_STEP_US / TICK_US;
   localparam int CAS_ON_TK     = CAS_ON_US / TICK_US;
   localparam int CAS_OFF_TK    = CAS_OFF_US / TICK_US;
   localparam int CPM_ON_TK     = CPM_ON_MS * 1000 / TICK_US;
   localparam int CPM_OFF_TK    = CPM_OFF_MS * 1000 / TICK_US;
   localparam int N_MAX         = 31;

   // Control register map, written over the serial data input.
   localparam logic [3:0] ADDR_MODE      = 4'h0;
   localparam logic [3:0] ADDR_HOLD_LOW  = 4'h1;
   localparam logic [3:0] ADDR_HOLD_HIGH = 4'h2;
   localparam int         MODE_SYNC_BIT  = 0;
   localparam int         MODE_CPM_BIT   = 1;
   localparam int         MODE_BOOST_BIT = 2;
   localparam int         HOLD_HIGH_BIT  = 0;
   localparam logic [3:0] MODE_RST       = 4'h0;
   localparam logic [3:0] HOLD_LOW_RST   = 4'h0;
   localparam logic       HOLD_HIGH_RST  = 1'b0;

   // Order of the synchronised pin inputs.
   localparam int PIN_DEMOD  = 0;
   localparam int PIN_ACCESS = 1;
   localparam int PIN_SCLK   = 2;
   localparam int PIN_SDI    = 3;
   localparam int PIN_CAS    = 4;
   localparam int PIN_CPM    = 5;
   localparam int PIN_NUM    = 6;

   typedef struct packed {
      logic [3:0] data;
      logic [3:0] addr;
   } cidr_wr_type;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_BITS = 2'b01,
      RX_STOP = 2'b10,
      RX_HOLD = 2'b11
   } cidr_rx_type;

   typedef enum logic [1:0] {
      RD_EMPTY = 2'b00,
      RD_FULL  = 2'b01,
      RD_SYNC  = 2'b10,
      RD_ASYNC = 2'b11
   } cidr_rd_type;
endpackage : cidr_pkg

// File: design/cidr_serial_readout.sv
`timescale 1ns/100ps
module cidr_serial_readout
   import cidr_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int BIT_CYCLES  = BIT_CYC
) (
   input  wire logic clock_i,
   input  wire logic nrst_i,
   input  wire logic demod_data_i,
   input  wire logic access_select_0_i,
   input  wire logic serial_clk_i,
   input  wire logic serial_data_in_i,
   input  wire logic cas_tone_i,
   input  wire logic call_progress_tone_i,
   output logic      serial_data_out_o,
   output logic      data_ready_n_o,
   output logic      carrier_detect_n_o,
   output logic      boosted_level_mode_o
);

   function automatic logic [11:0] hold_ticks(input logic on,
                                              input logic [4:0] n);
      int t;
      t = on ? CAS_STEP_TK * (int'(n) + 2) + CAS_ON_TK
             : CAS_STEP_TK * (N_MAX - int'(n)) + CAS_OFF_TK;
      return t[11:0];
   endfunction : hold_ticks

   logic [PIN_NUM-1:0] sync1_q, sync2_q;
   logic               sclk_prev_q;
   genvar gi;
   generate
      for (gi = 0; gi < PIN_NUM; gi++) begin : g_sync
         always_ff @(posedge clock_i or negedge nrst_i) begin
            if (!nrst_i) begin
               // Each stage starts at its pin's idle level, so no false edge.
               sync1_q[gi] <= (gi == PIN_CAS || gi == PIN_CPM) ? 1'b0 : 1'b1;
               sync2_q[gi] <= (gi == PIN_CAS || gi == PIN_CPM) ? 1'b0 : 1'b1;
            end else begin
               sync1_q[gi] <= gi == PIN_DEMOD ? demod_data_i
                            : gi == PIN_ACCESS ? access_select_0_i
                            : gi == PIN_SCLK ? serial_clk_i
                            : gi == PIN_SDI ? serial_data_in_i
                            : gi == PIN_CAS ? cas_tone_i
                            : call_progress_tone_i;
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) sclk_prev_q <= 1'b1;
      else         sclk_prev_q <= sync2_q[PIN_SCLK];
   end

   logic sclk_rise, sclk_fall, access_lo;
   assign sclk_rise = sync2_q[PIN_SCLK] & ~sclk_prev_q;
   assign sclk_fall = ~sync2_q[PIN_SCLK] & sclk_prev_q;
   assign access_lo = ~sync2_q[PIN_ACCESS];

   // Control register writes.
   logic [3:0]  mode_q, hold_low_q;
   logic        hold_high_q, armed_q;
   logic [2:0]  wcnt_q;
   cidr_wr_type wr_q, wr_next;
   logic [4:0]  thresh;
   assign thresh  = {hold_high_q, hold_low_q};
   assign wr_next = {sync2_q[PIN_SDI], wr_q[7:1]};

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         armed_q <= 1'b0;
         wcnt_q  <= 3'h0;
         wr_q    <= '0;
      end else if (access_lo) begin
         armed_q <= 1'b1;
         wcnt_q  <= 3'h0;
      end else if (armed_q && sclk_rise) begin
         wr_q   <= wr_next;
         wcnt_q <= wcnt_q + 3'h1;
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mode_q      <= MODE_RST;
         hold_low_q  <= HOLD_LOW_RST;
         hold_high_q <= HOLD_HIGH_RST;
      end else if (!access_lo && armed_q && sclk_rise && wcnt_q == 3'h7) begin
         // Last data bit completes the frame; address sits in the low half.
         case (wr_next.addr)
            ADDR_MODE:      mode_q      <= wr_next.data;
            ADDR_HOLD_LOW:  hold_low_q  <= wr_next.data;
            ADDR_HOLD_HIGH: hold_high_q <= wr_next.data[HOLD_HIGH_BIT];
            default: ;
         endcase
      end
   end

   // Slow time base shared by the tone detectors.
   logic [19:0] tick_cnt_q;
   logic        tick;
   assign tick = tick_cnt_q == 20'(TICK_CYCLES - 1);
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i)   tick_cnt_q <= 20'h0;
      else if (tick) tick_cnt_q <= 20'h0;
      else           tick_cnt_q <= tick_cnt_q + 20'h1;
   end

   // Dual-tone detect; a tone shorter than the hold never reaches the pin.
   logic [11:0] cas_cnt_q, cpm_cnt_q;
   logic        cd_n_q, cpm_det_q;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cd_n_q    <= 1'b1;
         cas_cnt_q <= 12'h0;
      end else if (sync2_q[PIN_CAS] != cd_n_q) begin
         cas_cnt_q <= 12'h0;
      end else if (tick) begin
         if (cas_cnt_q + 12'h1 >= hold_ticks(cd_n_q, thresh)) begin
            cd_n_q    <= ~cd_n_q;
            cas_cnt_q <= 12'h0;
         end else begin
            cas_cnt_q <= cas_cnt_q + 12'h1;
         end
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cpm_det_q <= 1'b0;
         cpm_cnt_q <= 12'h0;
      end else if (sync2_q[PIN_CPM] == cpm_det_q) begin
         cpm_cnt_q <= 12'h0;
      end else if (tick) begin
         if (cpm_cnt_q + 12'h1 >=
             12'(cpm_det_q ? CPM_OFF_TK : CPM_ON_TK)) begin
            cpm_det_q <= ~cpm_det_q;
            cpm_cnt_q <= 12'h0;
         end else begin
            cpm_cnt_q <= cpm_cnt_q + 12'h1;
         end
      end
   end

   // Character receiver; it waits in hold while the buffer is full.
   cidr_rx_type rx_q;
   logic [19:0] rx_cnt_q;
   logic [3:0]  rx_bit_q;
   logic [7:0]  rx_byte_q;
   logic        buf_ready, buf_valid;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_q      <= RX_IDLE;
         rx_cnt_q  <= 20'h0;
         rx_bit_q  <= 4'h0;
         rx_byte_q <= 8'h00;
      end else begin
         rx_cnt_q <= rx_cnt_q - 20'h1;
         case (rx_q)
            RX_IDLE: if (!sync2_q[PIN_DEMOD]) begin
               rx_q     <= RX_BITS;
               rx_bit_q <= 4'h0;
               rx_cnt_q <= 20'(BIT_CYCLES + BIT_CYCLES / 2);
            end
            RX_BITS: if (rx_cnt_q == 20'h0) begin
               rx_byte_q <= {sync2_q[PIN_DEMOD], rx_byte_q[7:1]};
               rx_bit_q  <= rx_bit_q + 4'h1;
               rx_cnt_q  <= 20'(BIT_CYCLES - 1);
               if (rx_bit_q == 4'h7) rx_q <= RX_STOP;
            end
            RX_STOP: if (rx_cnt_q == 20'h0) begin
               rx_q <= sync2_q[PIN_DEMOD] ? RX_HOLD : RX_IDLE;
            end
            RX_HOLD: if (buf_ready) rx_q <= RX_IDLE;
            default: rx_q <= RX_IDLE;
         endcase
      end
   end

   // Two-entry buffer between receiver and readout register.
   logic [7:0] buf_mem_q [2];
   logic       buf_wp_q, buf_rp_q;
   logic [1:0] buf_cnt_q;
   logic       push, pop;
   cidr_rd_type rd_q;
   assign buf_ready = buf_cnt_q != 2'h2;
   assign buf_valid = buf_cnt_q != 2'h0;
   assign push      = rx_q == RX_HOLD && buf_ready;
   assign pop       = rd_q == RD_EMPTY && buf_valid;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         buf_wp_q  <= 1'b0;
         buf_rp_q  <= 1'b0;
         buf_cnt_q <= 2'h0;
         buf_mem_q <= '{8'h00, 8'h00};
      end else begin
         if (push) begin
            buf_mem_q[buf_wp_q] <= rx_byte_q;
            buf_wp_q            <= ~buf_wp_q;
         end
         if (pop) buf_rp_q <= ~buf_rp_q;
         buf_cnt_q <= buf_cnt_q + 2'(push) - 2'(pop);
      end
   end

   // Readout of the held byte.
   logic [7:0]  shreg_q;
   logic [3:0]  rd_bit_q;
   logic [19:0] tx_cnt_q;
   logic        sdo_q;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_q     <= RD_EMPTY;
         shreg_q  <= 8'h00;
         rd_bit_q <= 4'h0;
         tx_cnt_q <= 20'h0;
         sdo_q    <= 1'b1;
      end else begin
         tx_cnt_q <= tx_cnt_q - 20'h1;
         // A released select puts the data pin back to its idle level unless an async readout is running.
         if (!access_lo && rd_q != RD_ASYNC) sdo_q <= 1'b1;
         case (rd_q)
            RD_EMPTY: if (buf_valid) begin
               // Loading only when empty keeps the byte steady during readout.
               shreg_q <= buf_mem_q[buf_rp_q];
               rd_q    <= RD_FULL;
            end
            RD_FULL: if (access_lo && mode_q[MODE_SYNC_BIT]) begin
               rd_q     <= RD_SYNC;
               rd_bit_q <= 4'h0;
            end else if (access_lo) begin
               rd_q     <= RD_ASYNC;
               rd_bit_q <= 4'h0;
               sdo_q    <= 1'b0;
               tx_cnt_q <= 20'(BIT_CYCLES - 1);
            end
            RD_SYNC: if (!access_lo) begin
               rd_q <= RD_FULL;
            end else if (sclk_fall) begin
               sdo_q <= shreg_q[rd_bit_q[2:0]];
            end else if (sclk_rise) begin
               rd_bit_q <= rd_bit_q + 4'h1;
               if (rd_bit_q == 4'h7) rd_q <= RD_EMPTY;
            end
            RD_ASYNC: if (tx_cnt_q == 20'h0) begin
               tx_cnt_q <= 20'(BIT_CYCLES - 1);
               rd_bit_q <= rd_bit_q + 4'h1;
               if (rd_bit_q == 4'h9) begin
                  rd_q  <= RD_EMPTY;
                  sdo_q <= 1'b1;
               end else begin
                  sdo_q <= rd_bit_q == 4'h8 ? 1'b1
                                            : shreg_q[rd_bit_q[2:0]];
               end
            end
            default: rd_q <= RD_EMPTY;
         endcase
      end
   end

   // Output flops; call-progress mode lends the data-ready pin to the tone.
   logic irq_n_q, boost_q;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_n_q <= 1'b1;
         boost_q <= 1'b0;
      end else begin
         irq_n_q <= mode_q[MODE_CPM_BIT] ? ~cpm_det_q
                                         : rd_q == RD_EMPTY;
         boost_q <= mode_q[MODE_BOOST_BIT];
      end
   end

   assign serial_data_out_o    = sdo_q;
   assign data_ready_n_o       = irq_n_q;
   assign carrier_detect_n_o   = cd_n_q;
   assign boosted_level_mode_o = boost_q;

endmodule : cidr_serial_readout

// File: verif/cidr_readout_assertions.sv
`timescale 1ns/100ps
module cidr_readout_assertions #(
   parameter int TICK_CYCLES = 10
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic demod_data_i,
   input wire logic access_select_0_i,
   input wire logic serial_clk_i,
   input wire logic serial_data_in_i,
   input wire logic cas_tone_i,
   input wire logic call_progress_tone_i,
   input wire logic serial_data_out_o,
   input wire logic data_ready_n_o,
   input wire logic carrier_detect_n_o,
   input wire logic boosted_level_mode_o
);
   int on_q;
   int off_q;

   // Raw pin counts run ahead of the synchronised ones, so bounds stay safe.
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         on_q  <= 0;
         off_q <= 0;
      end else begin
         on_q  <= cas_tone_i ? on_q + 1 : 0;
         off_q <= cas_tone_i ? 0 : off_q + 1;
      end
   end

   default clocking @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   a_reset_idle: assert property ($rose(nrst_i) |-> serial_data_out_o &&
      data_ready_n_o && carrier_detect_n_o && !boosted_level_mode_o)
      else $error("outputs not idle after reset");
   a_sdo_idle_high: assert property (
      access_select_0_i [*8] |-> serial_data_out_o)
      else $error("data out not idle while deselected");
   a_start_needs_select: assert property (
      $fell(serial_data_out_o) |-> !access_select_0_i)
      else $error("data out active while deselected");
   a_cd_on_wait: assert property (
      $fell(carrier_detect_n_o) |-> on_q >= 224 * TICK_CYCLES)
      else $error("carrier detect fell too early");
   a_cd_off_wait: assert property (
      $rose(carrier_detect_n_o) |-> off_q >= 130 * TICK_CYCLES)
      else $error("carrier detect rose too early");
   a_cd_hold_low: assert property (
      !carrier_detect_n_o && cas_tone_i |=> !carrier_detect_n_o)
      else $error("carrier detect released with tone present");
   a_boost_on_write: assert property ($changed(boosted_level_mode_o) |->
      $past(access_select_0_i, 1) && $past(access_select_0_i, 6))
      else $error("boost changed outside a write");
   a_boost_after_clk: assert property ($changed(boosted_level_mode_o) |->
      $past(serial_clk_i, 1) && $past(serial_clk_i, 2))
      else $error("boost changed away from a clock rise");
endmodule : cidr_readout_assertions

// File: verif/cidr_host_model.sv
`timescale 1ns/100ps
module cidr_host_model
   import cidr_pkg::*;
#(
   parameter int BIT_CYCLES = 40
) (
   input  wire logic clock_i,
   input  wire logic serial_data_out_i,
   output logic      access_select_0_o,
   output logic      serial_clk_o,
   output logic      serial_data_in_o
);
   initial begin
      access_select_0_o = 1'b1;
      serial_clk_o      = 1'b1;
      serial_data_in_o  = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask : tick

   // One clock cycle: data changes at the fall, data out taken at the rise.
   task automatic shift(input logic b, output logic s);
      serial_data_in_o <= b;
      serial_clk_o     <= 1'b0;
      tick(50);
      s = serial_data_out_i;
      serial_clk_o <= 1'b1;
      tick(50);
   endtask : shift

   task automatic write_reg(input logic [3:0] a, input logic [3:0] d);
      cidr_wr_type w;
      logic        s;
      w.addr = a;
      w.data = d;
      access_select_0_o <= 1'b0;
      tick(100);
      access_select_0_o <= 1'b1;
      tick(100);
      for (int i = 0; i < 8; i++) shift(w[i], s);
      serial_data_in_o <= ~w[7];
      tick(100);
   endtask : write_reg

   task automatic read_sync(output logic [7:0] v);
      access_select_0_o <= 1'b0;
      tick(100);
      for (int i = 0; i < 8; i++) shift(~serial_data_in_o, v[i]);
      tick(10);
      access_select_0_o <= 1'b1;
      tick(100);
   endtask : read_sync

   task automatic read_async(output logic [7:0] v);
      int n;
      v = 'x;
      n = 0;
      access_select_0_o <= 1'b0;
      while (serial_data_out_i && n < 1000) begin
         tick(1);
         n++;
      end
      if (n < 1000) begin
         tick(BIT_CYCLES / 2);
         for (int i = 0; i < 8; i++) begin
            tick(BIT_CYCLES);
            v[i] = serial_data_out_i;
         end
         tick(2 * BIT_CYCLES);
      end
      access_select_0_o <= 1'b1;
      tick(100);
   endtask : read_async
endmodule : cidr_host_model

// File: verif/cidr_serial_readout_bench.sv
`timescale 1ns/100ps
module cidr_serial_readout_bench
   import cidr_pkg::*;
;
   localparam int TK = 10;
   localparam int BC = 40;
   logic       clock_i;
   logic       nrst_i;
   logic       demod_data_i;
   logic       cas_tone_i;
   logic       call_progress_tone_i;
   logic       access_select_0_i;
   logic       serial_clk_i;
   logic       serial_data_in_i;
   logic       serial_data_out_o;
   logic       data_ready_n_o;
   logic       carrier_detect_n_o;
   logic       boosted_level_mode_o;
   int         errors;
   int         num_checks;
   logic [7:0] got;
   logic [8:0] rows [4] = '{9'h1a5, 9'h03c, 9'h180, 9'h001};
   logic [7:0] burst [3] = '{8'hc3, 8'h96, 8'h2d};

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   cidr_serial_readout #(.TICK_CYCLES(TK), .BIT_CYCLES(BC)) u_dut (
      .clock_i(clock_i), .nrst_i(nrst_i), .demod_data_i(demod_data_i),
      .access_select_0_i(access_select_0_i), .serial_clk_i(serial_clk_i),
      .serial_data_in_i(serial_data_in_i), .cas_tone_i(cas_tone_i),
      .call_progress_tone_i(call_progress_tone_i),
      .serial_data_out_o(serial_data_out_o), .data_ready_n_o(data_ready_n_o),
      .carrier_detect_n_o(carrier_detect_n_o),
      .boosted_level_mode_o(boosted_level_mode_o));

   cidr_host_model #(.BIT_CYCLES(BC)) u_host (
      .clock_i(clock_i), .serial_data_out_i(serial_data_out_o),
      .access_select_0_o(access_select_0_i), .serial_clk_o(serial_clk_i),
      .serial_data_in_o(serial_data_in_i));

   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask : tick

   task automatic conclude;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude

   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t byte %h want %h", $time, g, e);
      end
   endtask : chk_byte

   task automatic chk_bit(input logic g, input logic e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t flag %b want %b", $time, g, e);
      end
   endtask : chk_bit

   task automatic wait_drdy(input logic v);
      int n;
      n = 0;
      while (data_ready_n_o !== v && n < 5000) begin
         tick(1);
         n++;
      end
      if (n >= 5000) begin
         errors++;
         $display("BAD %0t wait timed out", $time);
         conclude();
      end
   endtask : wait_drdy

   task automatic send_line(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         demod_data_i <= f[i];
         tick(BC);
      end
   endtask : send_line

   initial begin
      nrst_i = 1'b0;
      demod_data_i = 1'b1;
      cas_tone_i = 1'b0;
      call_progress_tone_i = 1'b0;
      errors = 0;
      num_checks = 0;
      tick(16);
      nrst_i <= 1'b1;
      tick(2);
      chk_byte({4'h0, serial_data_out_o, data_ready_n_o, carrier_detect_n_o,
                boosted_level_mode_o}, 8'h0e);
      foreach (rows[i]) begin
         u_host.write_reg(ADDR_MODE, {3'h0, rows[i][8]});
         send_line(rows[i][7:0]);
         wait_drdy(1'b0);
         if (rows[i][8]) u_host.read_sync(got);
         else u_host.read_async(got);
         chk_byte(got, rows[i][7:0]);
         wait_drdy(1'b1);
      end
      // Three back-to-back bytes with no read in between fill the readout register and both buffer entries.
      u_host.write_reg(ADDR_MODE, 4'h1);
      foreach (burst[i]) send_line(burst[i]);
      foreach (burst[i]) begin
         wait_drdy(1'b0);
         u_host.read_sync(got);
         chk_byte(got, burst[i]);
      end
      u_host.write_reg(4'h3, 4'h4);
      chk_bit(boosted_level_mode_o, 1'b0);
      u_host.write_reg(ADDR_MODE, 4'h4);
      chk_bit(boosted_level_mode_o, 1'b1);
      u_host.write_reg(ADDR_MODE, 4'h0);
      chk_bit(boosted_level_mode_o, 1'b0);
      u_host.write_reg(ADDR_HOLD_LOW, 4'h1);
      u_host.write_reg(ADDR_HOLD_HIGH, 4'h1);
      cas_tone_i <= 1'b1;
      tick((28 * 19 + 169 - 2) * TK);
      chk_bit(carrier_detect_n_o, 1'b1);
      tick(5 * TK);
      chk_bit(carrier_detect_n_o, 1'b0);
      cas_tone_i <= 1'b0;
      tick((28 * 14 + 131 - 2) * TK);
      chk_bit(carrier_detect_n_o, 1'b0);
      tick(5 * TK);
      chk_bit(carrier_detect_n_o, 1'b1);
      u_host.write_reg(ADDR_MODE, 4'h2);
      call_progress_tone_i <= 1'b1;
      tick(248 * TK);
      chk_bit(data_ready_n_o, 1'b1);
      tick(5 * TK);
      chk_bit(data_ready_n_o, 1'b0);
      call_progress_tone_i <= 1'b0;
      tick(298 * TK);
      chk_bit(data_ready_n_o, 1'b0);
      tick(5 * TK);
      chk_bit(data_ready_n_o, 1'b1);
      conclude();
   end
endmodule : cidr_serial_readout_bench

bind cidr_serial_readout cidr_readout_assertions #(
   .TICK_CYCLES(TICK_CYCLES)) u_chk (
   .clock_i(clock_i), .nrst_i(nrst_i), .demod_data_i(demod_data_i),
   .access_select_0_i(access_select_0_i), .serial_clk_i(serial_clk_i),
   .serial_data_in_i(serial_data_in_i), .cas_tone_i(cas_tone_i),
   .call_progress_tone_i(call_progress_tone_i),
   .serial_data_out_o(serial_data_out_o), .data_ready_n_o(data_ready_n_o),
   .carrier_detect_n_o(carrier_detect_n_o),
   .boosted_level_mode_o(boosted_level_mode_o));
